// *** hw/touch_sleep_debounce_config.sv ***
// The Avalon-MM interface to the registers was left to the implementer.
module touch_sleep_debounce_config #(
	parameter int MS_CYCLES = touch_cfg_pkg::MS_CYCLES_DEFAULT
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [11:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	input wire logic [7:0] i_touch_raw,
	input wire logic [7:0] i_strength_top,
	input wire logic [7:0] i_active_mask,
	output logic [7:0] o_touch_valid,
	output logic [7:0] o_strongest,
	output logic o_scanning,
	output logic o_sleeping,
	output logic o_irq
);
	import touch_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	// only the second stage is read, so a metastable first stage never reaches logic
	logic [7:0] touch_s1_r, touch_s2_r, top_s1_r, top_s2_r;
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			touch_s1_r <= 8'h00;
			touch_s2_r <= 8'h00;
			top_s1_r <= 8'h00;
			top_s2_r <= 8'h00;
		end else begin
			touch_s1_r <= i_touch_raw;
			touch_s2_r <= touch_s1_r;
			top_s1_r <= i_strength_top;
			top_s2_r <= top_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers
	logic [15:0] idle_interval_config_r, sleep_period_config_r, touch_qualify_config_r;
	// low-power enable and a relative-mode flag that is only stored
	logic [1:0] ctrl_r;
	logic [2:0] irq_stat_r, irq_mask_r, irq_set;
	logic ack_r;
	logic [9:0] idx;
	logic wr, rd;
	// word index from the byte address; the two low address bits are ignored
	assign idx = i_address[11:2];
	// a write lands on the edge that ends the wait, where the master sees waitrequest low
	assign wr = i_write && ack_r;
	// read data are registered one edge early so they stand when the wait ends
	assign rd = i_read && !ack_r;
	// one wait state: waitrequest drops in the cycle after the request rises
	assign o_waitrequest = (i_read || i_write) && !ack_r;

	// byte-lane merge shared by the three 16-bit fields
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] be);
		merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	// ack is high for one cycle per request, so every access takes two cycles
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (i_read || i_write) && !ack_r;
		end
	end

	// configuration storage, cleared at reset
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			idle_interval_config_r <= RST_CFG;
			sleep_period_config_r <= RST_CFG;
			touch_qualify_config_r <= RST_CFG;
			ctrl_r <= 2'h0;
			irq_mask_r <= 3'h0;
		end else if (wr) begin
			if (idx == IDX_IDLE) begin
				idle_interval_config_r <= merge16(idle_interval_config_r, i_writedata, i_byteenable);
			end else if (idx == IDX_SLEEP) begin
				sleep_period_config_r <= merge16(sleep_period_config_r, i_writedata, i_byteenable);
			end else if (idx == IDX_QUAL) begin
				touch_qualify_config_r <= merge16(touch_qualify_config_r, i_writedata, i_byteenable);
			end else if (idx == IDX_CTRL && i_byteenable[0]) begin
				ctrl_r <= i_writedata[1:0];
			end else if (idx == IDX_MASK && i_byteenable[0]) begin
				irq_mask_r <= i_writedata[2:0];
			end
		end
	end

	// sticky status: a new event wins over a write-one clear
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			irq_stat_r <= 3'h0;
		end else if (wr && idx == IDX_IRQ && i_byteenable[0]) begin
			irq_stat_r <= (irq_stat_r & ~i_writedata[2:0]) | irq_set;
		end else begin
			irq_stat_r <= irq_stat_r | irq_set;
		end
	end
	assign o_irq = |(irq_stat_r & irq_mask_r);

	////////////////////////////////////////////////////////////////////////
	// phase sequencer and timebases
	phase_t phase_r;
	logic [3:0] n_active;
	logic osc_tick, ms_tick;
	logic [7:0] osc_div_r;
	logic [31:0] ms_div_r;
	logic ms_load, ms_done, osc_load, osc_done, ms_busy, osc_busy;
	logic [31:0] ms_count, osc_count;
	logic scan_end;

	// number of enabled sensors sets the scan length
	function automatic logic [3:0] popcount8(input logic [7:0] v);
		popcount8 = 4'h0;
		for (int i = 0; i < N_CH; i++) begin
			popcount8 = popcount8 + {3'h0, v[i]};
		end
	endfunction
	assign n_active = popcount8(i_active_mask);

	// internal oscillator divider: one tick per 2 us
	// restarting at one on a load keeps the idle exact, since done is registered
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			osc_div_r <= 8'h00;
		end else if (osc_load) begin
			osc_div_r <= 8'h01;
		end else if (osc_div_r == 8'(OSC_CYCLES - 1)) begin
			osc_div_r <= 8'h00;
		end else begin
			osc_div_r <= osc_div_r + 8'h01;
		end
	end
	assign osc_tick = (osc_div_r == 8'(OSC_CYCLES - 1));

	// millisecond divider
	// restarted with each load so scan and sleep last whole milliseconds
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ms_div_r <= 32'h00000000;
		end else if (ms_load) begin
			ms_div_r <= 32'h00000001;
		end else if (ms_div_r == 32'(MS_CYCLES - 1)) begin
			ms_div_r <= 32'h00000000;
		end else begin
			ms_div_r <= ms_div_r + 32'h00000001;
		end
	end
	assign ms_tick = (ms_div_r == 32'(MS_CYCLES - 1));

	// ms timer serves scan (2 ms per sensor) and sleep; osc timer serves idle
	cycle_timer u_ms_timer (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_load(ms_load),
		.i_count(ms_count),
		.i_tick(ms_tick),
		.o_done(ms_done),
		.o_busy(ms_busy)
	);
	cycle_timer u_osc_timer (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_load(osc_load),
		.i_count(osc_count),
		.i_tick(osc_tick),
		.o_done(osc_done),
		.o_busy(osc_busy)
	);

	// a scan counts as one sensor (2 ms) even with no sensors; only a scan entered from idle in low power with zero sleep loads zero and never ends
	assign ms_count = (phase_r == ST_IDLE && ctrl_r[CTRL_LOWPWR])
		? {16'h0000, sleep_period_config_r}
		: 32'(MS_PER_SENSOR) * ((n_active == 4'h0) ? 32'h1 : {28'h0, n_active});
	assign osc_count = {16'h0000, idle_interval_config_r} + 32'h00000001;
	assign scan_end = (phase_r == ST_SCAN) && ms_done;

	// a load straight out of reset starts the first scan
	logic started_r;
	assign ms_load = !started_r
		|| (phase_r == ST_IDLE && osc_done)
		|| (phase_r == ST_SLEEP && (ms_done || !ms_busy));
	assign osc_load = scan_end;

	// scan -> idle -> (sleep in low power) -> scan
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			phase_r <= ST_SCAN;
			started_r <= 1'b0;
		end else begin
			started_r <= 1'b1;
			case (phase_r)
				ST_SCAN: begin
					if (scan_end) begin
						phase_r <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (osc_done) begin
						// zero sleep time skips straight back to scanning
						if (ctrl_r[CTRL_LOWPWR] && sleep_period_config_r != 16'h0000) begin
							phase_r <= ST_SLEEP;
						end else begin
							phase_r <= ST_SCAN;
						end
					end
				end
				ST_SLEEP: begin
					if (ms_done || !ms_busy) begin
						phase_r <= ST_SCAN;
					end
				end
				default: begin
					phase_r <= ST_SCAN;
				end
			endcase
		end
	end
	// phase flags come straight from the state register
	assign o_scanning = (phase_r == ST_SCAN);
	assign o_sleeping = (phase_r == ST_SLEEP);

	////////////////////////////////////////////////////////////////////////
	// touch qualification, evaluated once per scan cycle
	logic [3:0] deb_cnt_r [N_CH];
	logic [11:0] swap_cnt_r;
	logic [7:0] cand_r;
	logic [7:0] seen;
	logic [3:0] deb_lim;
	logic [11:0] rep_lim;
	logic first_ev, swap_ev;
	// debounce count sits above the replacement count in one register
	assign deb_lim = touch_qualify_config_r[DEB_HI:DEB_LO];
	assign rep_lim = touch_qualify_config_r[REP_HI:REP_LO];
	// sleeping channels read as untouched whatever the pins say
	assign seen = (phase_r == ST_SLEEP) ? 8'h00 : (touch_s2_r & i_active_mask);

	// limit reached: the count so far plus this scan meets the programmed count
	function automatic logic at_limit(input logic [11:0] cnt, input logic [11:0] lim);
		at_limit = (cnt + 12'h001) >= lim;
	endfunction

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int i = 0; i < N_CH; i++) begin
				deb_cnt_r[i] <= 4'h0;
			end
			o_touch_valid <= 8'h00;
		end else if (scan_end) begin
			for (int i = 0; i < N_CH; i++) begin
				if (!seen[i]) begin
					deb_cnt_r[i] <= 4'h0;
					o_touch_valid[i] <= 1'b0;
				end else if (!o_touch_valid[i]) begin
					if (at_limit({8'h00, deb_cnt_r[i]}, {8'h00, deb_lim})) begin
						o_touch_valid[i] <= 1'b1;
					end else begin
						deb_cnt_r[i] <= deb_cnt_r[i] + 4'h1;
					end
				end
			end
		end
	end

	// a challenger must hold the top spot for the replacement count
	// in both absolute and relative modes, which only differ upstream
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_strongest <= 8'h00;
			cand_r <= 8'h00;
			swap_cnt_r <= 12'h000;
		end else if (scan_end) begin
			if ((top_s2_r & seen) == 8'h00) begin
				o_strongest <= 8'h00;
				cand_r <= 8'h00;
				swap_cnt_r <= 12'h000;
			end else if (o_strongest == 8'h00 || (top_s2_r & seen) == o_strongest) begin
				o_strongest <= top_s2_r & seen;
				swap_cnt_r <= 12'h000;
			end else if ((top_s2_r & seen) != cand_r) begin
				cand_r <= top_s2_r & seen;
				swap_cnt_r <= 12'h001;
				if (rep_lim <= 12'h001) begin
					o_strongest <= top_s2_r & seen;
				end
			end else if (at_limit(swap_cnt_r, rep_lim)) begin
				o_strongest <= cand_r;
				swap_cnt_r <= 12'h000;
			end else begin
				swap_cnt_r <= swap_cnt_r + 12'h001;
			end
		end
	end

	// event strobes into the sticky status
	logic [7:0] valid_d_r, strong_d_r;
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			valid_d_r <= 8'h00;
			strong_d_r <= 8'h00;
		end else begin
			valid_d_r <= o_touch_valid;
			strong_d_r <= o_strongest;
		end
	end
	// first touch: nothing valid a cycle before; swap: one owner replaced by another
	assign first_ev = (valid_d_r == 8'h00) && (o_touch_valid != 8'h00);
	assign swap_ev = (strong_d_r != 8'h00) && (o_strongest != 8'h00) && (strong_d_r != o_strongest);
	assign irq_set = {scan_end, swap_ev, first_ev};

	////////////////////////////////////////////////////////////////////////
	// read data, registered one edge before the answering edge
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_readdata <= 32'h00000000;
		end else if (rd) begin
			if (idx == IDX_IDLE) begin
				o_readdata <= {16'h0000, idle_interval_config_r};
			end else if (idx == IDX_SLEEP) begin
				o_readdata <= {16'h0000, sleep_period_config_r};
			end else if (idx == IDX_QUAL) begin
				o_readdata <= {16'h0000, touch_qualify_config_r};
			end else if (idx == IDX_CTRL) begin
				o_readdata <= {30'h0, ctrl_r};
			end else if (idx == IDX_STAT) begin
				o_readdata <= {13'h0, phase_r, o_strongest, o_touch_valid};
			end else if (idx == IDX_IRQ) begin
				o_readdata <= {29'h0, irq_stat_r};
			end else if (idx == IDX_MASK) begin
				o_readdata <= {29'h0, irq_mask_r};
			end else begin
				o_readdata <= 32'h00000000; // unmapped reads zero
			end
		end
	end
endmodule // touch_sleep_debounce_config

// *** hw/touch_cfg_pkg.sv ***
// Contract
// - idle lasts (count plus one) oscillator periods
// - idle applies while channel inactive, 16 bits
// - all channels inactive during sleep period
// - sleep field is milliseconds asleep between scans
// - low power alternates active scan and sleep
// - first touch after debounce consecutive scan cycles
// - scan cycle is 2 ms per active sensor (code: 2 ms if none active; never ends after a zero-sleep low-power idle)
// - strongest swap after replacement consecutive cycles
// - replacement delay in absolute and relative modes
package touch_cfg_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int OSC_PERIOD_NS = 2000;
	localparam int OSC_CYCLES = (OSC_PERIOD_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int MS_PER_SENSOR = 2;
	localparam int MS_CYCLES_DEFAULT = CLK_HZ / 1000;
	localparam int N_CH = 8;
	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_IDLE = 10'h055;
	localparam logic [9:0] IDX_SLEEP = 10'h056;
	localparam logic [9:0] IDX_QUAL = 10'h057;
	localparam logic [9:0] IDX_CTRL = 10'h058;
	localparam logic [9:0] IDX_STAT = 10'h059;
	localparam logic [9:0] IDX_IRQ = 10'h05A;
	localparam logic [9:0] IDX_MASK = 10'h05B;
	localparam logic [15:0] RST_CFG = 16'h0000;
	localparam int DEB_HI = 15;
	localparam int DEB_LO = 12;
	localparam int REP_HI = 11;
	localparam int REP_LO = 0;
	// control bits
	localparam int CTRL_LOWPWR = 0;
	localparam int CTRL_RELATIVE = 1;
	// irq bits
	localparam int IRQ_FIRST = 0;
	localparam int IRQ_SWAP = 1;
	localparam int IRQ_SCAN = 2;
	typedef enum logic [2:0] {
		ST_SCAN = 3'b001,
		ST_IDLE = 3'b010,
		ST_SLEEP = 3'b100
	} phase_t;
endpackage

// *** hw/cycle_timer.sv ***
// down counter; o_done pulses when a loaded count of enable ticks expires
module cycle_timer (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_load,
	input wire logic [31:0] i_count,
	input wire logic i_tick,
	output logic o_done,
	output logic o_busy
);
	logic [31:0] cnt_r;
	// load wins over counting so a restart never leaks a stale done
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_r <= 32'h00000000;
			o_done <= 1'b0;
		end else if (i_load) begin
			cnt_r <= i_count;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_tick && cnt_r != 32'h00000000) begin
				cnt_r <= cnt_r - 32'h00000001;
				if (cnt_r == 32'h00000001) begin
					o_done <= 1'b1;
				end
			end
		end
	end
	assign o_busy = (cnt_r != 32'h00000000);
endmodule // cycle_timer

// *** bench/touch_panel_model.sv ***
module touch_panel_model (
	input wire logic i_clk,
	input wire logic [7:0] i_press,
	input wire logic [7:0] i_top,
	output logic [7:0] o_touch_raw = 8'h00,
	output logic [7:0] o_strength_top = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	// electrodes answer a cycle late; a channel can only rank strongest while it is pressed
	always @(posedge i_clk) begin
		o_touch_raw <= i_press;
		o_strength_top <= i_top & i_press;
	end
endmodule // touch_panel_model

// *** bench/touch_cfg_properties.sv ***
module touch_cfg_properties #(
	parameter int MS_CYCLES = 20
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [11:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic o_waitrequest,
	input wire logic [7:0] i_active_mask,
	input wire logic [7:0] o_touch_valid,
	input wire logic [7:0] o_strongest,
	input wire logic o_scanning,
	input wire logic o_sleeping
);
	import touch_cfg_pkg::*;
	logic wr;
	logic idle;
	logic dirty_r;
	logic lp_r;
	logic [15:0] idle_r;
	logic [15:0] slp_r;
	int cnt_r;
	int act;
	assign wr = i_write && !o_waitrequest;
	assign idle = !o_scanning && !o_sleeping;
	assign act = (i_active_mask == 8'h00) ? 1 : $countones(i_active_mask);
	// shadow copies; a write marks every phase up to the next scan start as not judgeable
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			idle_r <= 16'h0000;
			slp_r <= 16'h0000;
			lp_r <= 1'b0;
			dirty_r <= 1'b1;
		end else begin
			if (wr && i_address == 12'h154) idle_r <= i_writedata[15:0];
			if (wr && i_address == 12'h158) slp_r <= i_writedata[15:0];
			if (wr && i_address == 12'h160) lp_r <= i_writedata[0];
			if (wr) dirty_r <= 1'b1;
			else if ($rose(o_scanning)) dirty_r <= 1'b0;
		end
	end
	// cycles spent so far in the current phase
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) cnt_r <= 1;
		else if ($changed({o_scanning, o_sleeping})) cnt_r <= 1;
		else cnt_r <= cnt_r + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);
	sequence scan_end_s;
		!dirty_r ##0 $fell(o_scanning);
	endsequence
	sequence idle_end_s;
		!dirty_r ##0 ($past(idle) && !idle);
	endsequence
	sequence sleep_end_s;
		!dirty_r ##0 $fell(o_sleeping);
	endsequence
	bus_wait_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("bus request not answered in its second cycle");
	phase_excl_a: assert property (!(o_scanning && o_sleeping))
		else $error("scan and sleep at once");
	scan_len_a: assert property (scan_end_s |-> cnt_r == 2 * MS_CYCLES * act)
		else $error("scan length wrong");
	idle_len_a: assert property (idle_end_s |-> cnt_r == (idle_r + 1) * OSC_CYCLES)
		else $error("idle length wrong");
	sleep_len_a: assert property (sleep_end_s |-> cnt_r == slp_r * MS_CYCLES)
		else $error("sleep length wrong");
	sleep_gate_a: assert property (!dirty_r ##0 $rose(o_sleeping) |-> lp_r && slp_r != 0)
		else $error("sleep entered while not enabled");
	sleep_frozen_a: assert property (o_sleeping && $past(o_sleeping) |->
		(o_touch_valid & ~$past(o_touch_valid)) == 8'h00)
		else $error("touch qualified during sleep");
	valid_end_a: assert property ((o_touch_valid & ~$past(o_touch_valid)) != 8'h00
		|-> $past(o_scanning) && !o_scanning)
		else $error("touch qualified outside scan end");
	strong_one_a: assert property ($onehot0(o_strongest))
		else $error("more than one strongest channel");
endmodule // touch_cfg_properties
bind touch_sleep_debounce_config touch_cfg_properties #(.MS_CYCLES(MS_CYCLES))
	touch_cfg_properties_i (.*);

// *** bench/touch_sleep_debounce_config_bench.sv ***
module touch_sleep_debounce_config_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import touch_cfg_pkg::*;
	localparam int MSC = 20;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [11:0] i_address = 12'h000;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = 32'h00000000;
	logic [3:0] i_byteenable = 4'h3;
	logic [7:0] i_active_mask = 8'h03;
	logic [31:0] o_readdata;
	logic o_waitrequest;
	logic [7:0] i_touch_raw;
	logic [7:0] i_strength_top;
	logic [7:0] o_touch_valid;
	logic [7:0] o_strongest;
	logic o_scanning;
	logic o_sleeping;
	logic o_irq;
	logic [7:0] press = 8'h00;
	logic [7:0] pick = 8'h00;
	logic [31:0] rd_v;
	int bad_count = 0;
	int checks_done = 0;
	int n;
	// two active sensors: one scan is 4 ms of shortened time
	touch_sleep_debounce_config #(.MS_CYCLES(MSC)) touch_sleep_debounce_config_i (.*);
	touch_panel_model touch_panel_model_i (
		.i_clk(i_clk),
		.i_press(press),
		.i_top(pick),
		.o_touch_raw(i_touch_raw),
		.o_strength_top(i_strength_top)
	);
	always #25 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one Avalon access; the request is held until waitrequest is seen low
	task automatic bus(input logic w, input logic [9:0] idx, input logic [15:0] d);
		int k;
		@(posedge i_clk);
		i_read <= !w;
		i_write <= w;
		i_address <= {idx, 2'b00};
		i_writedata <= {16'h0000, d};
		for (k = 0; k < 20; k++) begin
			@(posedge i_clk);
			if (o_waitrequest === 1'b0) break;
		end
		rd_v = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
		if (k == 20) begin
			bad_count++;
			summarize();
		end
	endtask
	// bounded wait for the scan flag; a long sleep still fits the bound
	task automatic wait_scan(input logic lvl);
		int k;
		for (k = 0; k < 3000; k++) begin
			@(posedge i_clk);
			if (o_scanning === lvl) break;
		end
		if (k == 3000) begin
			bad_count++;
			summarize();
		end
	endtask
	task automatic scan_end();
		wait_scan(1'b1);
		wait_scan(1'b0);
	endtask
	task automatic scans_to(input logic s, input logic [7:0] tgt);
		for (n = 1; n < 20; n++) begin
			scan_end();
			if ((s ? o_strongest : o_touch_valid) === tgt) break;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// reset values, full 16-bit fields, one lane only, unmapped place
	task automatic t_regs();
		for (int i = 0; i < 3; i++) begin
			bus(1'b0, IDX_IDLE + 10'(i), 16'h0000);
			check(rd_v, 32'h00000000);
			bus(1'b1, IDX_IDLE + 10'(i), 16'hA5C3);
			bus(1'b0, IDX_IDLE + 10'(i), 16'h0000);
			check(rd_v, 32'h0000A5C3);
		end
		i_byteenable <= 4'h1;
		bus(1'b1, IDX_IDLE, 16'h0002);
		i_byteenable <= 4'h3;
		bus(1'b0, IDX_IDLE, 16'h0000);
		check(rd_v, 32'h0000A502);
		bus(1'b1, IDX_IDLE, 16'h0002);
		bus(1'b0, 10'h3FF, 16'h0000);
		check(rd_v, 32'h00000000);
	endtask
	// debounce of three scans, then the first-touch interrupt
	task automatic t_qual();
		bus(1'b1, IDX_QUAL, 16'h3002);
		scan_end();
		check(o_irq, 1'b0);
		bus(1'b0, IDX_IRQ, 16'h0000);
		check(rd_v, 32'h00000004);
		wait_scan(1'b1);
		press <= 8'h01;
		scans_to(1'b0, 8'h01);
		check(n, 3);
		bus(1'b1, IDX_MASK, 16'h0001);
		@(posedge i_clk);
		check(o_irq, 1'b1);
		bus(1'b1, IDX_IRQ, 16'h0001);
		@(posedge i_clk);
		check(o_irq, 1'b0);
		press <= 8'h00;
		// qualification only moves at a scan end, so a release shows there
		scan_end();
		check(o_touch_valid, 8'h00);
	endtask
	// swap of the strongest touch after two scans, absolute then relative
	task automatic t_swap();
		press <= 8'h03;
		pick <= 8'h01;
		scans_to(1'b1, 8'h01);
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, IDX_CTRL, 16'(m << CTRL_RELATIVE));
			scan_end();
			wait_scan(1'b1);
			pick <= (m == 0) ? 8'h02 : 8'h01;
			scans_to(1'b1, (m == 0) ? 8'h02 : 8'h01);
			check(n, 2);
		end
		// first touch, swap and scan-end events are all pending, then cleared together
		bus(1'b0, IDX_IRQ, 16'h0000);
		check(rd_v, 32'h00000007);
		bus(1'b1, IDX_IRQ, 16'h0007);
		bus(1'b0, IDX_IRQ, 16'h0000);
		check(rd_v, 32'h00000000);
		// status in idle: phase idle, channel 0 strongest, both channels valid
		bus(1'b0, IDX_STAT, 16'h0000);
		check(rd_v, 32'h00020103);
	endtask
	// low-power duty cycle: idle of three oscillator periods, sleep of 2 ms
	task automatic t_sleep();
		bus(1'b1, IDX_SLEEP, 16'h0002);
		bus(1'b1, IDX_CTRL, 16'h0001);
		scan_end();
		scan_end();
		for (n = 0; n < 999 && !o_scanning && !o_sleeping; n++) @(posedge i_clk);
		check(n, 3 * OSC_CYCLES);
		check(o_sleeping, 1'b1);
		for (n = 0; n < 999 && o_sleeping; n++) @(posedge i_clk);
		check(n, 2 * MSC);
		check(o_touch_valid, 8'h03);
		bus(1'b1, IDX_CTRL, 16'h0000);
		scan_end();
	endtask
	initial begin
		repeat (4) @(posedge i_clk);
		i_reset <= 1'b0;
		t_regs();
		t_qual();
		t_swap();
		t_sleep();
		summarize();
	end
endmodule // touch_sleep_debounce_config_bench
